// ---- design/mgmt_passthrough.sv ----
// management pass-through: receive filtering, host copy, fragment pool and APB registers
// How it works
// - nothing reaches the management controller unless rx_to_controller_enable (bit 17) is set.
// - with mgmt_to_host_forward_enable (bit 21) set, filter-matched traffic is also copied to the host.
// - a filter only routes traffic once its own enable bit is set.
// - with the remote-management host block set, packets to UDP port 0x26F never reach the host.
// - transmit writes are refused while the receive buffer is full of unread data.
// - a transaction carries at most 240 bytes and no more than the fragment size (default 32).
// - at initialisation the 3 KB pool is split into pool size divided by fragment size buffers.
// - each fragment takes a whole buffer, and a transaction needing more than are free is refused.
// - with checksum filtering on, only packets with a valid checksum go to the controller.
`timescale 1ns/1ps
module mgmt_passthrough #(
  parameter int TAG_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [mgmt_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // received packet descriptors from the network side
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [TAG_W-1:0] rx_tag,
  input wire logic [mgmt_pkg::NUM_FILTERS-1:0] rx_filter_hit,
  input wire logic rx_csum_ok,
  input wire logic [15:0] rx_udp_port,
  // toward the management controller
  output logic ctl_valid,
  input wire logic ctl_ready,
  output logic [TAG_W-1:0] ctl_tag,
  // toward the host
  output logic host_valid,
  output logic [TAG_W-1:0] host_tag,
  // sideband write transactions
  input wire logic txn_req,
  input wire logic [7:0] txn_bytes,
  input wire logic [mgmt_pkg::COUNT_W-1:0] txn_frags,
  output logic txn_ack,
  output logic txn_nack,
  // buffer release after a packet is consumed
  input wire logic frag_release,
  input wire logic [mgmt_pkg::COUNT_W-1:0] release_count
);
  import mgmt_pkg::*;

  function automatic reg_sel_e decode(input logic [APB_AW-1:0] addr);
    if (addr == MGMT_CTRL_ADDR) begin
      decode = REG_CTRL;
    end else if (addr == FRAG_CFG_ADDR) begin
      decode = REG_FRAG;
    end else if (addr == POOL_STAT_ADDR) begin
      decode = REG_STAT;
    end else begin
      decode = REG_NONE;
    end
  endfunction : decode

  logic [31:0] management_control;
  logic [7:0] frag_size;
  pool_state_e state;
  logic [COUNT_W-1:0] remain;
  logic [COUNT_W-1:0] total;
  logic [COUNT_W-1:0] free;
  logic [COUNT_W-1:0] next_free;
  logic reinit;
  logic apb_done;
  reg_sel_e sel;
  logic rx_take;
  logic to_ctl;
  logic rmcp_hit;
  logic to_host;
  logic take_ok;
  logic [COUNT_W:0] sum;

  assign sel = decode(paddr);
  assign apb_done = psel && penable && pready;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= (sel == REG_NONE);
      if (pwrite || sel == REG_NONE) begin
        prdata <= '0;
      end else if (sel == REG_CTRL) begin
        prdata <= management_control;
      end else if (sel == REG_FRAG) begin
        prdata <= {24'h00_0000, frag_size};
      end else begin
        prdata <= {2'b00, !rx_ready, (state == ST_INIT), total, 4'h0, free};
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      management_control <= MGMT_CTRL_RESET;
    end else if (apb_done && pwrite && sel == REG_CTRL) begin
      management_control <= pwdata & MGMT_CTRL_WMASK;
    end
  end

  // out-of-range sizes are clamped so the pool split never divides by zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frag_size <= FRAG_DEFAULT;
    end else if (apb_done && pwrite && sel == REG_FRAG) begin
      if (pwdata[7:0] < FRAG_MIN) begin
        frag_size <= FRAG_MIN;
      end else if (pwdata[31:8] != 24'h00_0000 || pwdata[7:0] > FRAG_MAX) begin
        frag_size <= FRAG_MAX;
      end else begin
        frag_size <= pwdata[7:0];
      end
    end
  end

  assign reinit = apb_done && pwrite && sel == REG_FRAG;

  // receive routing
  assign rx_take = rx_valid && rx_ready;
  assign to_ctl = management_control[RX_TO_CTL_BIT]
    && |(rx_filter_hit & management_control[FILTER_LSB +: NUM_FILTERS])
    && (!management_control[CSUM_FILTER_BIT] || rx_csum_ok);
  assign rmcp_hit = management_control[RMCP_HOST_BLOCK_BIT] && rx_udp_port == RMCP_PORT;
  assign to_host = (!to_ctl || management_control[M2H_BIT]) && !rmcp_hit;

  // a stalled controller back-pressures the whole receive stream
  two_entry_buffer #(
    .WIDTH(TAG_W)
  ) u_ctl_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(rx_valid && to_ctl),
    .in_data(rx_tag),
    .in_ready(rx_ready),
    .out_valid(ctl_valid),
    .out_data(ctl_tag),
    .out_ready(ctl_ready)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_valid <= 1'b0;
      host_tag <= '0;
    end else begin
      host_valid <= rx_take && to_host;
      if (rx_take && to_host) begin
        host_tag <= rx_tag;
      end
    end
  end

  // transaction acceptance
  assign take_ok = state == ST_RUN
    && rx_ready
    && txn_bytes != 8'h00 && txn_bytes <= frag_size
    && txn_frags != '0 && txn_frags <= free;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txn_ack <= 1'b0;
      txn_nack <= 1'b0;
    end else begin
      txn_ack <= txn_req && take_ok;
      txn_nack <= txn_req && !take_ok;
    end
  end

  always_comb begin
    sum = {1'b0, free} + {1'b0, release_count};
    if (txn_req && take_ok) begin
      sum = sum - {1'b0, txn_frags};
    end
    if (sum > {1'b0, total}) begin
      next_free = total;
    end else begin
      next_free = sum[COUNT_W-1:0];
    end
  end

  // pool split by repeated subtraction; one buffer per step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_INIT;
      remain <= POOL_BYTES;
      total <= '0;
      free <= '0;
    end else if (reinit) begin
      state <= ST_INIT;
      remain <= POOL_BYTES;
      total <= '0;
      free <= '0;
    end else begin
      case (state)
        ST_INIT: begin
          if (remain >= {4'h0, frag_size}) begin
            remain <= remain - {4'h0, frag_size};
            total <= total + 12'h001;
          end else begin
            state <= ST_RUN;
            free <= total;
          end
        end
        ST_RUN: begin
          if (frag_release) begin
            free <= next_free;
          end else if (txn_req && take_ok) begin
            free <= free - txn_frags;
          end
        end
        default: begin
          state <= ST_INIT;
        end
      endcase
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence rx_taken_idle;
    rx_valid && rx_ready && !ctl_valid;
  endsequence

  sequence init_done;
    state == ST_INIT ##1 state == ST_RUN;
  endsequence

  chk_rx_enable_gate: assert property (
    rx_taken_idle and !management_control[RX_TO_CTL_BIT] |=> !ctl_valid
  ) else $error("packet reached controller with receive enable clear");

  chk_host_copy: assert property (
    rx_valid && rx_ready && to_ctl && !rmcp_hit |=> host_valid == $past(management_control[M2H_BIT])
  ) else $error("host copy of matched traffic disagrees with forward enable");

  chk_filter_enable: assert property (
    rx_taken_idle and management_control[FILTER_LSB +: NUM_FILTERS] == '0 |=> !ctl_valid
  ) else $error("disabled filters routed a packet to the controller");

  chk_rmcp_block: assert property (
    rx_valid && rx_ready && management_control[RMCP_HOST_BLOCK_BIT] && rx_udp_port == RMCP_PORT
      |=> !host_valid
  ) else $error("reserved port packet reached the host");

  chk_backlog_nack: assert property (
    txn_req && !rx_ready |=> txn_nack && !txn_ack
  ) else $error("write accepted while receive buffer full");

  chk_frag_limit: assert property (
    txn_req && (txn_bytes > frag_size || txn_bytes > FRAG_MAX) |=> txn_nack ##1 !txn_ack
  ) else $error("oversized transaction not refused");

  chk_pool_split: assert property (
    init_done |-> total == POOL_BYTES / {4'h0, frag_size} && free == total
  ) else $error("pool split does not match fragment size");

  chk_no_memory: assert property (
    state == ST_RUN && txn_req && txn_frags > free && !reinit
      |=> txn_nack && !txn_ack && ($past(frag_release) || free == $past(free))
  ) else $error("transaction needing too many buffers not refused");

  chk_csum_drop: assert property (
    rx_taken_idle and management_control[CSUM_FILTER_BIT] && !rx_csum_ok |=> !ctl_valid
  ) else $error("bad checksum packet passed to controller");

  chk_release_return: assert property (
    state == ST_RUN && frag_release && !txn_req && !reinit
      && {1'b0, free} + {1'b0, release_count} <= {1'b0, total}
      |=> free == $past(free) + $past(release_count)
  ) else $error("released buffers not returned to pool");

  chk_txn_answer: assert property (
    txn_req |=> txn_ack != txn_nack
  ) else $error("sideband write not answered by exactly one of ack and nack");

  chk_stall_hold: assert property (
    ctl_valid && !ctl_ready |=> ctl_valid && $stable(ctl_tag)
  ) else $error("stalled controller word changed or was dropped");
endmodule : mgmt_passthrough

// ---- design/mgmt_pkg.sv ----
// constants, register map and types for the management pass-through block
package mgmt_pkg;
  localparam int APB_AW = 16;
  localparam int COUNT_W = 12;
  localparam int NUM_FILTERS = 4;

  localparam logic [APB_AW-1:0] MGMT_CTRL_ADDR = 16'h5820;
  localparam logic [APB_AW-1:0] FRAG_CFG_ADDR = 16'h5824;
  localparam logic [APB_AW-1:0] POOL_STAT_ADDR = 16'h5828;

  // management_control fields
  localparam int FILTER_LSB = 0;
  localparam int CSUM_FILTER_BIT = 4;
  localparam int RMCP_HOST_BLOCK_BIT = 5;
  localparam int RX_TO_CTL_BIT = 17;
  localparam int M2H_BIT = 21;
  localparam logic [31:0] MGMT_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MGMT_CTRL_WMASK = 32'h0022_003F;

  // pool status fields
  localparam int FREE_LSB = 0;
  localparam int TOTAL_LSB = 16;
  localparam int INIT_BUSY_BIT = 28;
  localparam int BACKLOG_BIT = 29;

  localparam logic [7:0] FRAG_DEFAULT = 8'h20;
  localparam logic [7:0] FRAG_MIN = 8'h01;
  localparam logic [7:0] FRAG_MAX = 8'hF0;
  localparam logic [COUNT_W-1:0] POOL_BYTES = 12'hC00;
  localparam logic [15:0] RMCP_PORT = 16'h026F;

  typedef enum logic [1:0] {
    REG_NONE = 2'b00,
    REG_CTRL = 2'b01,
    REG_FRAG = 2'b10,
    REG_STAT = 2'b11
  } reg_sel_e;

  typedef enum logic [0:0] {
    ST_INIT = 1'b0,
    ST_RUN = 1'b1
  } pool_state_e;
endpackage : mgmt_pkg

// ---- design/two_entry_buffer.sv ----
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic tail_valid;
  logic [WIDTH-1:0] tail_data;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // head register feeds the port directly, tail only absorbs a stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
      tail_valid <= 1'b0;
      tail_data <= '0;
    end else if (!out_valid) begin
      out_valid <= push;
      if (push) begin
        out_data <= in_data;
      end
    end else if (pop) begin
      if (tail_valid) begin
        out_data <= tail_data;
        tail_valid <= push;
        if (push) begin
          tail_data <= in_data;
        end
      end else begin
        out_valid <= push;
        if (push) begin
          out_data <= in_data;
        end
      end
    end else if (push) begin
      tail_valid <= 1'b1;
      tail_data <= in_data;
    end
  end

  // ready is a flop: full only when the tail holds a word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ready <= 1'b1;
    end else if (!out_valid || pop) begin
      in_ready <= 1'b1;
    end else begin
      in_ready <= !(tail_valid || push);
    end
  end
endmodule : two_entry_buffer

// ---- bench/mc_partner.sv ----
// management controller model: consumes the controller stream and can stall it
`timescale 1ns/1ps
module ctl_partner (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // stream from the block
  input wire logic ctl_valid,
  input wire logic [15:0] ctl_tag,
  output logic ctl_ready,
  // bench control and observation
  input wire logic stall,
  output logic [31:0] ctl_cnt,
  output logic [15:0] ctl_last
);
  // ready lags stall by one edge, as a firmware poll loop would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ready <= 1'b0;
    end else begin
      ctl_ready <= !stall;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_cnt <= 32'h0;
      ctl_last <= 16'h0;
    end else if (ctl_valid && ctl_ready) begin
      ctl_cnt <= ctl_cnt + 32'h1;
      ctl_last <= ctl_tag;
    end
  end
endmodule : ctl_partner

// ---- bench/mgmt_passthrough_tb_top.sv ----
// self-checking bench for the management pass-through block
`timescale 1ns/1ps
module mgmt_passthrough_tb_top;
  import mgmt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 16'h0, rx_tag = 16'h0, rx_udp_port = 16'h0, ctl_last, host_tag, host_last = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv, ctl_cnt, host_cnt = 32'h0;
  logic pready, pslverr, rx_valid = 0, rx_ready, rx_csum_ok = 0, ctl_valid, ctl_ready, host_valid, last_err;
  logic [3:0] rx_filter_hit = 4'h0;
  logic [15:0] ctl_tag;
  logic txn_req = 0, txn_ack, txn_nack, frag_release = 0, stall = 0;
  logic [7:0] txn_bytes = 8'h0;
  logic [11:0] txn_frags = 12'h0, release_count = 12'h0;
  int err_count = 0, n_checks = 0, k;

  always #5 pclk = ~pclk;

  mgmt_passthrough dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_tag(rx_tag), .rx_filter_hit(rx_filter_hit), .rx_csum_ok(rx_csum_ok),
    .rx_udp_port(rx_udp_port), .ctl_valid(ctl_valid), .ctl_ready(ctl_ready), .ctl_tag(ctl_tag),
    .host_valid(host_valid), .host_tag(host_tag), .txn_req(txn_req), .txn_bytes(txn_bytes),
    .txn_frags(txn_frags), .txn_ack(txn_ack), .txn_nack(txn_nack), .frag_release(frag_release),
    .release_count(release_count));

  ctl_partner ctl_u (.pclk(pclk), .presetn(presetn), .ctl_valid(ctl_valid), .ctl_tag(ctl_tag),
    .ctl_ready(ctl_ready), .stall(stall), .ctl_cnt(ctl_cnt), .ctl_last(ctl_last));

  // host copies are one-cycle pulses, so count them at every edge
  always @(posedge pclk) begin
    if (host_valid === 1'b1) begin
      host_cnt <= host_cnt + 32'h1;
      host_last <= host_tag;
    end
  end

  task complete_run;
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    // no local limit: only the watchdog ends a hung access
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rdv = prdata;
    last_err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task rd_chk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdv, exp);
  endtask : rd_chk

  task wait_init;
    do begin apb(1'b0, POOL_STAT_ADDR, 32'h0); end while (rdv[INIT_BUSY_BIT] !== 1'b0);
  endtask : wait_init

  task txn(input logic [7:0] b, input logic [11:0] f, input logic ok);
    @(posedge pclk);
    txn_req <= 1; txn_bytes <= b; txn_frags <= f;
    @(posedge pclk);
    txn_req <= 0;
    #1 check({30'h0, txn_ack, txn_nack}, {30'h0, ok, !ok});
  endtask : txn

  task send(input logic [15:0] t, input logic [3:0] h, input logic c, input logic [15:0] p);
    @(posedge pclk);
    rx_valid <= 1; rx_tag <= t; rx_filter_hit <= h; rx_csum_ok <= c; rx_udp_port <= p;
    do begin @(posedge pclk); end while (rx_ready !== 1'b1);
    rx_valid <= 0;
  endtask : send

  task pkt(input logic [15:0] t, input logic [3:0] h, input logic c, input logic [15:0] p, input logic em,
           input logic eh);
    logic [31:0] m0, h0;
    m0 = ctl_cnt;
    h0 = host_cnt;
    send(t, h, c, p);
    repeat (5) @(posedge pclk);
    check(ctl_cnt - m0, {31'h0, em});
    check(host_cnt - h0, {31'h0, eh});
    if (em) check({16'h0, ctl_last}, {16'h0, t});
    if (eh) check({16'h0, host_last}, {16'h0, t});
  endtask : pkt

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    txn(8'd32, 12'd1, 1'b0);
    rd_chk(MGMT_CTRL_ADDR, MGMT_CTRL_RESET);
    rd_chk(FRAG_CFG_ADDR, 32'h20);
    rd_chk(16'h5830, 32'h0);
    check({31'h0, last_err}, 32'h1);
    wait_init();
    rd_chk(POOL_STAT_ADDR, 32'h0060_0060);
    txn(8'd33, 12'd1, 1'b0);
    txn(8'd32, 12'd96, 1'b1);
    rd_chk(POOL_STAT_ADDR, 32'h0060_0000);
    txn(8'd32, 12'd1, 1'b0);
    @(posedge pclk);
    frag_release <= 1; release_count <= 12'd96;
    @(posedge pclk);
    frag_release <= 0;
    rd_chk(POOL_STAT_ADDR, 32'h0060_0060);
    apb(1'b1, MGMT_CTRL_ADDR, 32'hFFFF_FFFF);
    rd_chk(MGMT_CTRL_ADDR, MGMT_CTRL_WMASK);
    // over-range size clamps to the largest fragment
    apb(1'b1, FRAG_CFG_ADDR, 32'h0000_00FF);
    rd_chk(FRAG_CFG_ADDR, 32'hF0);
    wait_init();
    rd_chk(POOL_STAT_ADDR, 32'h000C_000C);
    txn(8'd240, 12'd13, 1'b0);
    txn(8'd240, 12'd1, 1'b1);
    apb(1'b1, MGMT_CTRL_ADDR, 32'h0000_000F);
    pkt(16'h0001, 4'h1, 1, 16'h0, 0, 1);
    apb(1'b1, MGMT_CTRL_ADDR, 32'h0002_0000);
    pkt(16'h0002, 4'hF, 1, 16'h0, 0, 1);
    apb(1'b1, MGMT_CTRL_ADDR, 32'h0002_0001);
    pkt(16'h0003, 4'h1, 1, 16'h0, 1, 0);
    pkt(16'h0004, 4'h2, 1, 16'h0, 0, 1);
    apb(1'b1, MGMT_CTRL_ADDR, 32'h0022_0001);
    pkt(16'h0005, 4'h1, 1, 16'h0, 1, 1);
    apb(1'b1, MGMT_CTRL_ADDR, 32'h0002_0011);
    pkt(16'h0006, 4'h1, 0, 16'h0, 0, 1);
    pkt(16'h0007, 4'h1, 1, 16'h0, 1, 0);
    apb(1'b1, MGMT_CTRL_ADDR, 32'h0002_0021);
    pkt(16'h0008, 4'h0, 1, RMCP_PORT, 0, 0);
    pkt(16'h0009, 4'h0, 1, 16'h0270, 0, 1);
    apb(1'b1, MGMT_CTRL_ADDR, 32'h0022_0021);
    pkt(16'h000A, 4'h1, 1, RMCP_PORT, 1, 0);
    apb(1'b1, MGMT_CTRL_ADDR, 32'h0002_0001);
    @(posedge pclk);
    stall <= 1;
    rdv = ctl_cnt;
    k = 0;
    repeat (4) begin
      repeat (2) @(posedge pclk);
      if (rx_ready === 1'b1) begin
        send(16'h0100 + 16'(k), 4'h1, 1, 16'h0);
        k++;
      end
    end
    check({31'h0, rx_ready}, 32'h0);
    txn(8'd32, 12'd1, 1'b0);
    @(posedge pclk);
    stall <= 0;
    repeat (8) @(posedge pclk);
    check(ctl_cnt - rdv, 32'(k));
    txn(8'd32, 12'd1, 1'b1);
    complete_run();
  end
endmodule : mgmt_passthrough_tb_top
